// File: mwd_pkg.sv
// Constants for the register-write and diagnosis function handler.
// Assumes a framer delivering request bytes and a serializer taking reply bytes.
// What this block does
// - Multi no-save write: code 0x42, start address, count 1 to 16.
// - Byte count equals twice the register count, then two bytes per register.
// - Multi-write success reply: code, start address, register count, no data.
// - Each register word travels high byte first, low byte second.
// - Failure reply is request code plus 0x80 and one exception byte.
// - No-save write to a run-locked parameter is refused with exception 1.
// - Diagnosis request: code 0x08, 16-bit sub-function, 16-bit data word.
// - Diagnosis reply repeats code and sub-function unchanged.
// - Sub-function 0000 returns the received data word exactly.
// - Diagnosis never touches parameter registers or application state.
// - Code 0x06 writes one register to working and non-volatile store.
// - Single-write reply echoes code, address, value after update completes.
// - Code 0x41 is 0x06 layout but writes working memory only.
// - Working-memory write acts at once; power-up restores saved value.
package mwd_pkg;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_WR_SAVE = 8'h06;
    localparam logic [7:0] FC_WR_RAM = 8'h41;
    localparam logic [7:0] FC_WR_MULTI = 8'h42;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;
    localparam logic [15:0] SUB_LOOPBACK = 16'h0000;
    localparam logic [7:0] EXC_LOCKED = 8'h01;
    localparam logic [7:0] EXC_BAD_SUB = 8'h01;
    localparam logic [7:0] EXC_BAD_DATA = 8'h03;
    localparam logic [15:0] MIN_REGS = 16'h0001;
    localparam logic [15:0] MAX_REGS = 16'h0010;
    // Byte positions within a request
    localparam logic [5:0] POS_FC = 6'h00;
    localparam logic [5:0] POS_ADDR_HI = 6'h01;
    localparam logic [5:0] POS_ADDR_LO = 6'h02;
    localparam logic [5:0] POS_WORD_HI = 6'h03;
    localparam logic [5:0] POS_WORD_LO = 6'h04;
    localparam logic [5:0] POS_BCNT = 6'h05;
    localparam logic [5:0] POS_DATA = 6'h06;
    localparam logic [5:0] POS_END = 6'h26;
    localparam logic [5:0] LEN_FIXED = 6'h05;
    localparam logic [5:0] LEN_SAT = 6'h3F;
    localparam logic [2:0] LAST_NORMAL = 3'h4;
    localparam logic [2:0] LAST_EXC = 3'h1;
    localparam int STAGE_DEPTH = 16;
    localparam int STAGE_AW = 4;

    typedef enum logic [2:0] {
        ST_RECV = 3'b000,
        ST_CHECK = 3'b001,
        ST_COMMIT = 3'b010,
        ST_NVWAIT = 3'b011,
        ST_REPLY = 3'b100
    } mwd_state_t;
endpackage

// File: mwd_stage_mem.sv
// Staging buffer holding multi-write data until the frame is validated.
// Assumes one write and one read port on the same clock.
`timescale 1ns/1ps
module mwd_stage_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic sys_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata_q
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule // mwd_stage_mem

// File: mwd_handler.sv
// Slave-side handler for diagnosis, single and multi register writes.
// Assumes bytes from a framer on sys_clk and a lock lookup answering combinationally.
`timescale 1ns/1ps
module mwd_handler (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_end,
    output logic rx_ready_q,
    output logic [7:0] tx_data_q,
    output logic tx_valid_q,
    output logic tx_last_q,
    input wire logic tx_ready,
    input wire logic drive_running,
    output logic [15:0] chk_addr_q,
    input wire logic lock_hit,
    output logic wm_we_q,
    output logic [15:0] wm_addr_q,
    output logic [15:0] wm_data_q,
    output logic nv_we_q,
    input wire logic nv_done
);
    import mwd_pkg::*;

    mwd_state_t st_q, st_d;
    logic [5:0] len_q;
    logic [7:0] fc_q;
    logic [15:0] a_q;
    logic [15:0] n_q;
    logic [7:0] bc_q;
    logic [7:0] hi_q;
    logic exc_q;
    logic [7:0] code_q;
    logic [4:0] i_q;
    logic ph_q;
    logic [2:0] tx_idx_q;
    logic [15:0] buf_rdata;

    function automatic logic [7:0] rep_byte(input logic [2:0] idx, input logic exc, input logic [7:0] fc,
                                            input logic [7:0] code, input logic [15:0] a, input logic [15:0] w);
        logic [7:0] b;
        b = 8'h00;
        if (exc)
        begin
            b = (idx == 3'h0) ? (fc | FC_EXC_FLAG) : code;
        end
        else
        begin
            unique case (idx)
                3'h0: b = fc;
                3'h1: b = a[15:8];
                3'h2: b = a[7:0];
                3'h3: b = w[15:8];
                3'h4: b = w[7:0];
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction

    // Byte capture and frame decode
    wire take_byte = (st_q == ST_RECV) && rx_valid && !rx_end;
    wire frame_end = (st_q == ST_RECV) && rx_end;
    wire [5:0] data_k = len_q - POS_DATA;
    wire in_data = (len_q >= POS_DATA) && (len_q < POS_END);
    wire stage_we = take_byte && in_data && data_k[0];
    wire [15:0] stage_wdata = {hi_q, rx_data};
    wire is_multi = fc_q == FC_WR_MULTI;
    wire is_diag = fc_q == FC_DIAG;
    wire is_known = is_diag || is_multi || (fc_q == FC_WR_SAVE) || (fc_q == FC_WR_RAM);
    wire n_ok = (n_q >= MIN_REGS) && (n_q <= MAX_REGS);
    wire bc_ok = bc_q == {n_q[6:0], 1'b0};
    wire mlen_ok = len_q == (POS_DATA + {n_q[4:0], 1'b0});
    wire bad_data = is_multi ? !(n_ok && bc_ok && mlen_ok) : (len_q != LEN_FIXED);
    wire bad_sub = is_diag && (a_q != SUB_LOOPBACK);
    wire needs_check = is_multi || (fc_q == FC_WR_RAM);
    wire [4:0] last_i = is_multi ? (n_q[4:0] - 5'h01) : 5'h00;
    wire at_last = i_q == last_i;
    wire [15:0] cur_addr = a_q + {11'h000, i_q};
    wire locked = drive_running && lock_hit;
    wire [2:0] tx_last_idx = exc_q ? LAST_EXC : LAST_NORMAL;
    wire tx_adv = tx_valid_q && tx_ready;
    wire start_reply = (st_d == ST_REPLY) && (st_q != ST_REPLY);
    // Reply kind at start; exc_q may still hold the last frame's outcome
    wire start_exc = (st_q == ST_RECV) ? (bad_data || bad_sub) : (exc_q || ((st_q == ST_CHECK) && locked));

    mwd_stage_mem #(
        .WIDTH(16),
        .DEPTH(STAGE_DEPTH),
        .AW(STAGE_AW)
    ) u_stage (
        .sys_clk(sys_clk),
        .we(stage_we),
        .waddr(data_k[4:1]),
        .wdata(stage_wdata),
        .raddr(i_q[3:0]),
        .rdata_q(buf_rdata)
    );

    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_RECV:
            begin
                if (frame_end && is_known)
                begin
                    if (bad_data || bad_sub || is_diag)
                        st_d = ST_REPLY;
                    else if (needs_check)
                        st_d = ST_CHECK;
                    else
                        st_d = ST_COMMIT;
                end
            end
            ST_CHECK:
            begin
                if (ph_q && locked)
                    st_d = ST_REPLY;
                else if (ph_q && at_last)
                    st_d = ST_COMMIT;
            end
            ST_COMMIT:
            begin
                if (ph_q && at_last)
                    st_d = (fc_q == FC_WR_SAVE) ? ST_NVWAIT : ST_REPLY;
            end
            ST_NVWAIT:
            begin
                if (nv_done)
                    st_d = ST_REPLY;
            end
            ST_REPLY:
            begin
                if (tx_adv && (tx_idx_q == tx_last_idx))
                    st_d = ST_RECV;
            end
            default: st_d = ST_RECV;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            st_q <= ST_RECV;
        else
            st_q <= st_d;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || frame_end)
            len_q <= 6'h00;
        else if (take_byte && (len_q != LEN_SAT))
            len_q <= len_q + 6'h01;
    end

    // Request fields, words high byte first
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            fc_q <= 8'h00;
            a_q <= 16'h0000;
            n_q <= 16'h0000;
            bc_q <= 8'h00;
            hi_q <= 8'h00;
        end
        else if (take_byte)
        begin
            unique case (len_q)
                POS_FC: fc_q <= rx_data;
                POS_ADDR_HI: a_q[15:8] <= rx_data;
                POS_ADDR_LO: a_q[7:0] <= rx_data;
                POS_WORD_HI: n_q[15:8] <= rx_data;
                POS_WORD_LO: n_q[7:0] <= rx_data;
                POS_BCNT: bc_q <= rx_data;
                default: hi_q <= rx_data;
            endcase
        end
    end

    // Exception outcome
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || (frame_end && is_known))
        begin
            exc_q <= !sys_rst && (bad_data || bad_sub);
            code_q <= bad_data ? EXC_BAD_DATA : EXC_BAD_SUB;
        end
        else if ((st_q == ST_CHECK) && ph_q && locked)
        begin
            exc_q <= 1'b1;
            code_q <= EXC_LOCKED;
        end
    end

    // Word walker for lock check and commit, two cycles per word
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || (st_q != st_d))
        begin
            i_q <= 5'h00;
            ph_q <= 1'b0;
        end
        else if ((st_q == ST_CHECK) || (st_q == ST_COMMIT))
        begin
            ph_q <= !ph_q;
            if (ph_q)
                i_q <= i_q + 5'h01;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            chk_addr_q <= 16'h0000;
        else if ((st_q == ST_CHECK) && !ph_q)
            chk_addr_q <= cur_addr;
    end

    // Working and non-volatile write strobes
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            wm_we_q <= 1'b0;
            nv_we_q <= 1'b0;
            wm_addr_q <= 16'h0000;
            wm_data_q <= 16'h0000;
        end
        else
        begin
            wm_we_q <= (st_q == ST_COMMIT) && ph_q;
            nv_we_q <= (st_q == ST_COMMIT) && ph_q && (fc_q == FC_WR_SAVE);
            if ((st_q == ST_COMMIT) && ph_q)
            begin
                wm_addr_q <= cur_addr;
                wm_data_q <= is_multi ? buf_rdata : n_q;
            end
        end
    end

    // Reply byte stream
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            tx_idx_q <= 3'h0;
            tx_data_q <= 8'h00;
        end
        else if (start_reply)
        begin
            tx_valid_q <= 1'b1;
            tx_last_q <= 1'b0;
            tx_idx_q <= 3'h0;
            tx_data_q <= rep_byte(3'h0, start_exc, fc_q, 8'h00, a_q, n_q);
        end
        else if (tx_adv)
        begin
            tx_valid_q <= tx_idx_q != tx_last_idx;
            tx_idx_q <= tx_idx_q + 3'h1;
            tx_last_q <= (tx_idx_q + 3'h1) == tx_last_idx;
            tx_data_q <= rep_byte(tx_idx_q + 3'h1, exc_q, fc_q, code_q, a_q, n_q);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            rx_ready_q <= 1'b1;
        else
            rx_ready_q <= st_d == ST_RECV;
    end

    AST_EXC_FC: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_valid_q && exc_q && (tx_idx_q == 3'h0) |-> tx_data_q == (fc_q | FC_EXC_FLAG))
        else $error("exception reply code wrong");
    AST_LOCK_REFUSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_q == ST_CHECK) && ph_q && locked |=> exc_q && (code_q == EXC_LOCKED) && (st_q == ST_REPLY) && !wm_we_q)
        else $error("locked write not refused");
    AST_DIAG_NO_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wm_we_q || nv_we_q |-> fc_q != FC_DIAG)
        else $error("diagnosis wrote a register");
    AST_BAD_COUNT: assert property (@(posedge sys_clk) disable iff (sys_rst)
        frame_end && is_multi && !(n_ok && bc_ok) |=> exc_q && (code_q == EXC_BAD_DATA) && (st_q == ST_REPLY))
        else $error("bad count not refused");
    AST_MULTI_RANGE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wm_we_q && is_multi |-> (n_q >= MIN_REGS) && (n_q <= MAX_REGS) && (bc_q == {n_q[6:0], 1'b0}))
        else $error("multi write with illegal count");
    AST_NV_ONLY_SAVE: assert property (@(posedge sys_clk) disable iff (sys_rst)
        nv_we_q |-> (fc_q == FC_WR_SAVE) && wm_we_q)
        else $error("non-volatile write from wrong code");
    AST_REPLY_AFTER_NV: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_q == ST_NVWAIT) && !nv_done |=> !tx_valid_q && (st_q == ST_NVWAIT))
        else $error("reply before update complete");
    AST_LOOPBACK: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_valid_q && !exc_q && is_diag && (tx_idx_q == 3'h4) |-> tx_data_q == n_q[7:0] && tx_last_q)
        else $error("loopback data mismatch");
    AST_ECHO_FC: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_valid_q && !exc_q && (tx_idx_q == 3'h0) |-> tx_data_q == fc_q)
        else $error("reply code not echoed");
    AST_ADDR_HI_FIRST: assert property (@(posedge sys_clk) disable iff (sys_rst)
        tx_adv && !exc_q && (tx_idx_q == 3'h0) |=> tx_data_q == a_q[15:8] ##1 1'b1)
        else $error("address high byte not first");

    COV_DIAG: cover property (@(posedge sys_clk) tx_valid_q && is_diag && !exc_q && tx_last_q);
    COV_MULTI: cover property (@(posedge sys_clk) wm_we_q && is_multi && at_last);
    COV_LOCK: cover property (@(posedge sys_clk) (st_q == ST_CHECK) && ph_q && locked);
    COV_NV: cover property (@(posedge sys_clk) (st_q == ST_NVWAIT) && nv_done);
endmodule // mwd_handler

// File: mwd_far_model.sv
// Far-side model: reply sink, run-lock table and non-volatile store.
// Assumes the handler's reply, lock and store ports on one clock.
`timescale 1ns/1ps
module mwd_far_model (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic slow,
    input wire logic [7:0] tx_data_q,
    input wire logic tx_valid_q,
    input wire logic tx_last_q,
    output logic tx_ready,
    input wire logic [15:0] chk_addr_q,
    input wire logic [15:0] lock_addr,
    output logic lock_hit,
    input wire logic nv_we_q,
    output logic nv_done
);
    logic [7:0] rep [0:7];
    logic [3:0] rep_n = 4'h0;
    logic fin = 1'h0;
    logic tgl_q = 1'h0;
    logic [2:0] nv_cnt = 3'h0;
    // Slow sink accepts on every other cycle
    assign tx_ready = !slow || tgl_q;
    assign lock_hit = chk_addr_q == lock_addr;
    // Save completes a few cycles after the strobe
    assign nv_done = nv_cnt == 3'h1;
    always_ff @(posedge sys_clk)
    begin
        tgl_q <= !tgl_q;
        if (clr)
        begin
            rep_n <= 4'h0;
            fin <= 1'h0;
            nv_cnt <= 3'h0;
        end
        else
        begin
            if (tx_valid_q && tx_ready)
            begin
                rep[rep_n[2:0]] <= tx_data_q;
                rep_n <= rep_n + 4'h1;
                fin <= tx_last_q;
            end
            if (nv_we_q)
                nv_cnt <= 3'h4;
            else if (nv_cnt != 3'h0)
                nv_cnt <= nv_cnt - 3'h1;
        end
    end
endmodule // mwd_far_model

// File: mwd_handler_tb_top.sv
// Testbench for the function handler: each scenario sends request frames.
// Assumes mwd_far_model as reply sink, lock table and save store.
`timescale 1ns/1ps
module mwd_handler_tb_top;
    import mwd_pkg::*;
    logic sys_clk;
    logic sys_rst = 1'h1;
    logic [7:0] rx_data = 8'h00;
    logic rx_valid = 1'h0;
    logic rx_end = 1'h0;
    logic drive_running = 1'h0;
    logic clr = 1'h1;
    logic slow = 1'h0;
    logic [15:0] lock_addr = 16'hFFFF;
    logic rx_ready_q, tx_valid_q, tx_last_q, tx_ready, lock_hit, wm_we_q, nv_we_q, nv_done;
    logic [7:0] tx_data_q;
    logic [15:0] chk_addr_q, wm_addr_q, wm_data_q;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int wm_n, nv_n, nv_at, tv_at;
    logic tv_seen;
    logic [15:0] wa [0:15];
    logic [15:0] wd [0:15];
    logic [7:0] fq [$];
    logic [7:0] eq [$];

    mwd_handler uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_end(rx_end), .rx_ready_q(rx_ready_q), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
        .tx_last_q(tx_last_q), .tx_ready(tx_ready), .drive_running(drive_running), .chk_addr_q(chk_addr_q),
        .lock_hit(lock_hit), .wm_we_q(wm_we_q), .wm_addr_q(wm_addr_q), .wm_data_q(wm_data_q),
        .nv_we_q(nv_we_q), .nv_done(nv_done));
    mwd_far_model far (.sys_clk(sys_clk), .clr(clr), .slow(slow), .tx_data_q(tx_data_q),
        .tx_valid_q(tx_valid_q), .tx_last_q(tx_last_q), .tx_ready(tx_ready), .chk_addr_q(chk_addr_q),
        .lock_addr(lock_addr), .lock_hit(lock_hit), .nv_we_q(nv_we_q), .nv_done(nv_done));

    initial
    begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Watches store strobes and reply start
    always @(posedge sys_clk)
    begin
        cyc++;
        if (wm_we_q === 1'h1)
        begin
            wa[wm_n[3:0]] = wm_addr_q;
            wd[wm_n[3:0]] = wm_data_q;
            wm_n++;
        end
        if (nv_we_q === 1'h1)
        begin
            nv_n++;
            nv_at = cyc;
        end
        if (tx_valid_q === 1'h1 && !tv_seen)
        begin
            tv_seen = 1'h1;
            tv_at = cyc;
        end
        if (cyc == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Word fields go high byte first
    task automatic hdr(input logic [7:0] fc, input logic [15:0] a, input logic [15:0] w);
        fq = {fc, a[15:8], a[7:0], w[15:8], w[7:0]};
    endtask

    task automatic xfer(input int n_wr, input int n_nv);
        int t;
        t = 0;
        wm_n = 0;
        nv_n = 0;
        tv_seen = 1'h0;
        clr = 1'h1;
        @(posedge sys_clk);
        #1;
        clr = 1'h0;
        while (rx_ready_q !== 1'h1 && t < 100)
        begin
            @(posedge sys_clk);
            #1;
            t++;
        end
        foreach (fq[i])
        begin
            rx_valid = 1'h1;
            rx_data = fq[i];
            @(posedge sys_clk);
            #1;
        end
        rx_valid = 1'h0;
        @(posedge sys_clk);
        #1;
        rx_end = 1'h1;
        @(posedge sys_clk);
        #1;
        rx_end = 1'h0;
        check("rx_ready_busy", {15'h0000, rx_ready_q}, 16'h0000);
        t = 0;
        while (far.fin !== 1'h1 && t < 300)
        begin
            @(posedge sys_clk);
            #1;
            t++;
        end
        check("rx_ready_idle", {15'h0000, rx_ready_q}, 16'h0001);
        check("reply_len", 16'(far.rep_n), 16'(eq.size()));
        foreach (eq[i])
            check("reply_byte", {8'h00, far.rep[i]}, {8'h00, eq[i]});
        check("wm_writes", 16'(wm_n), 16'(n_wr));
        check("nv_writes", 16'(nv_n), 16'(n_nv));
    endtask

    task automatic t_diag();
        slow = 1'h1;
        hdr(FC_DIAG, SUB_LOOPBACK, 16'hA537);
        eq = fq;
        xfer(0, 0);
        slow = 1'h0;
        hdr(FC_DIAG, 16'h0001, 16'h1234);
        eq = {FC_DIAG | FC_EXC_FLAG, EXC_BAD_SUB};
        xfer(0, 0);
        hdr(FC_DIAG, SUB_LOOPBACK, 16'h5AC3);
        eq = fq;
        xfer(0, 0);
    endtask

    task automatic t_ram();
        drive_running = 1'h1;
        lock_addr = 16'h7001;
        hdr(FC_WR_RAM, 16'h0007, 16'h1388);
        eq = fq;
        xfer(1, 0);
        check("wm_addr", wa[0], 16'h0007);
        check("wm_data", wd[0], 16'h1388);
        hdr(FC_WR_RAM, 16'h7001, 16'hEC78);
        eq = {FC_WR_RAM | FC_EXC_FLAG, EXC_LOCKED};
        xfer(0, 0);
        drive_running = 1'h0;
        eq = fq;
        xfer(1, 0);
    endtask

    task automatic t_save();
        drive_running = 1'h1;
        lock_addr = 16'h0001;
        hdr(FC_WR_SAVE, 16'h0001, 16'h0001);
        eq = fq;
        xfer(1, 1);
        check("wm_data", wd[0], 16'h0001);
        check("wm_addr", wa[0], 16'h0001);
        check("reply_after_save", 16'(tv_at > nv_at + 3), 16'h0001);
        fq = {FC_WR_SAVE, 8'h00, 8'h01, 8'h00};
        eq = {FC_WR_SAVE | FC_EXC_FLAG, EXC_BAD_DATA};
        xfer(0, 0);
    endtask

    // One multi-write; exc 00 means a normal reply is due
    task automatic mw(input logic [15:0] a, input int n, input logic [7:0] bc, input logic [7:0] exc);
        logic [15:0] w;
        fq = {FC_WR_MULTI, a[15:8], a[7:0], 8'h00, 8'(n), bc};
        for (int i = 0; i < n; i++)
        begin
            w = {8'hA0 + 8'(i), 8'h5C - 8'(i)};
            fq.push_back(w[15:8]);
            fq.push_back(w[7:0]);
        end
        if (exc == 8'h00)
        begin
            eq = {FC_WR_MULTI, a[15:8], a[7:0], 8'h00, 8'(n)};
            xfer(n, 0);
            for (int i = 0; i < n; i++)
            begin
                check("mw_addr", wa[i], a + 16'(i));
                check("mw_data", wd[i], {8'hA0 + 8'(i), 8'h5C - 8'(i)});
            end
        end
        else
        begin
            eq = {FC_WR_MULTI | FC_EXC_FLAG, exc};
            xfer(0, 0);
        end
    endtask

    task automatic t_multi();
        drive_running = 1'h0;
        mw(16'h000E, 2, 8'h04, 8'h00);
        mw(16'hFFF8, 16, 8'h20, 8'h00);
        mw(16'h0000, 0, 8'h00, EXC_BAD_DATA);
        mw(16'h0000, 17, 8'h22, EXC_BAD_DATA);
        mw(16'h0010, 1, 8'h03, EXC_BAD_DATA);
        drive_running = 1'h1;
        lock_addr = 16'h0011;
        mw(16'h0010, 2, 8'h04, EXC_LOCKED);
    endtask

    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1;
        sys_rst = 1'h0;
        clr = 1'h0;
        t_diag();
        t_ram();
        t_save();
        t_multi();
        final_report();
    end
endmodule // mwd_handler_tb_top
